// file: rtl/dnc_top.sv
// two downconverter channels and their tuning registers
// assumes eight converter samples per clock, oldest in lane 0,
// and a synchronous register port with writes and reads of one cycle
//
// Functional notes
// - two independent channels, each synthesizer, mixer, filters
// - ten-bit oscillator, 1024 steps of rate/1024
// - phase accumulator feeds a parabolic sine approximation for mixing
// - channel zero increment from high[1:0], low[7:0]
// - channel one increment from high[1:0], low[7:0]
// - high bandwidth: decimate by 8, 16-bit I/Q
// - low bandwidth: second stage decimates further by 2
// - second stage used only in low bandwidth
// - all logic on one clock, rate/8
// - polyphase first stage takes eight 13-bit samples per cycle
// - each stage gain 0 to 18 dB, 6 dB steps
// - first stage gain before scaling to 16 bits
// - first stage symmetric 142-tap fixed coefficient filter
// - second stage symmetric 31-tap fixed coefficient filter
// - second stage time-shares one engine for I and Q
// - second stage gain before quantizing to 16 bits
`timescale 1ns/1ps

module dnc_channel (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sample stream
    input wire logic [dnc_pkg::LANES-1:0][dnc_pkg::SMP_W-1:0] adcSamples,
    // configuration
    input wire logic [dnc_pkg::PH_W-1:0] tuneWord,
    input wire logic lowBandwidth,
    input wire logic [dnc_pkg::GAIN_W-1:0] gainFirst,
    input wire logic [dnc_pkg::GAIN_W-1:0] gainSecond,
    // result stream
    output dnc_pkg::dnc_iq_s outIq,
    output logic outValid
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // parabolic sine, one full turn per 1024 phase codes
    function automatic logic signed [11:0] sineOf(input logic [9:0] p);
        logic [16:0] mag;
        logic [8:0] h;
        h = p[8:0];
        mag = 17'(({8'h00, h} * (17'(dnc_pkg::SIN_HALF) - {8'h00, h})) >> dnc_pkg::SIN_SHIFT);
        if (mag > 17'(dnc_pkg::SIN_MAX)) begin
            mag = 17'(dnc_pkg::SIN_MAX);
        end
        sineOf = p[9] ? -$signed(12'(mag)) : $signed(12'(mag));
    endfunction

    // gain, round, shift down and saturate to the output word
    function automatic logic signed [15:0] scaleOut(input logic signed [43:0] a,
                                                    input logic [1:0] g, input int sh);
        logic signed [43:0] t;
        t = a <<< g;
        t = t + (44'sd1 <<< (sh - 1));
        t = t >>> sh;
        if (t > 44'(dnc_pkg::SAT_MAX)) begin
            scaleOut = 16'(dnc_pkg::SAT_MAX);
        end else if (t < 44'(dnc_pkg::SAT_MIN)) begin
            scaleOut = 16'(dnc_pkg::SAT_MIN);
        end else begin
            scaleOut = 16'(t);
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [9:0] phase_r, phase_nxt;
    logic signed [12:0] line1I_r [dnc_pkg::TAPS1];
    logic signed [12:0] line1I_nxt [dnc_pkg::TAPS1];
    logic signed [12:0] line1Q_r [dnc_pkg::TAPS1];
    logic signed [12:0] line1Q_nxt [dnc_pkg::TAPS1];
    logic signed [15:0] line2I_r [dnc_pkg::TAPS2];
    logic signed [15:0] line2I_nxt [dnc_pkg::TAPS2];
    logic signed [15:0] line2Q_r [dnc_pkg::TAPS2+1];
    logic signed [15:0] line2Q_nxt [dnc_pkg::TAPS2+1];
    dnc_pkg::dnc_iq_s s1_r, s1_nxt, out_r, out_nxt;
    logic s1Valid_r, s1Valid_nxt, outValid_r, outValid_nxt;
    logic signed [15:0] iHold_r, iHold_nxt;
    dnc_pkg::dnc_phase_e ph_r, ph_nxt;

    logic [9:0] lanePhase;
    logic signed [11:0] sinV, cosV;
    logic signed [23:0] prodI, prodQ;
    logic signed [12:0] mixI [dnc_pkg::LANES];
    logic signed [12:0] mixQ [dnc_pkg::LANES];
    logic signed [43:0] acc1I, acc1Q, acc2;
    logic signed [16:0] pair2;
    logic signed [15:0] res2;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        phase_nxt = phase_r + {tuneWord[6:0], 3'b000};
        lanePhase = '0;
        sinV = '0;
        cosV = '0;
        prodI = '0;
        prodQ = '0;
        for (int j = 0; j < dnc_pkg::LANES; j++) begin
            lanePhase = phase_r + 10'(tuneWord * 10'(j));
            sinV = sineOf(lanePhase);
            cosV = sineOf(lanePhase + 10'(dnc_pkg::SIN_QUART));
            prodI = $signed(adcSamples[j]) * cosV;
            prodQ = -($signed(adcSamples[j]) * sinV);
            mixI[j] = 13'(prodI >>> dnc_pkg::MIX_SHIFT);
            mixQ[j] = 13'(prodQ >>> dnc_pkg::MIX_SHIFT);
        end
        for (int k = 0; k < dnc_pkg::LANES; k++) begin
            line1I_nxt[k] = mixI[dnc_pkg::LANES-1-k];
            line1Q_nxt[k] = mixQ[dnc_pkg::LANES-1-k];
        end
        for (int k = dnc_pkg::LANES; k < dnc_pkg::TAPS1; k++) begin
            line1I_nxt[k] = line1I_r[k-dnc_pkg::LANES];
            line1Q_nxt[k] = line1Q_r[k-dnc_pkg::LANES];
        end
        acc1I = '0;
        acc1Q = '0;
        for (int k = 0; k < dnc_pkg::HALF1; k++) begin
            acc1I = acc1I + 44'(18'(dnc_pkg::COEF1[k]) *
                    (14'(line1I_nxt[k]) + 14'(line1I_nxt[dnc_pkg::TAPS1-1-k])));
            acc1Q = acc1Q + 44'(18'(dnc_pkg::COEF1[k]) *
                    (14'(line1Q_nxt[k]) + 14'(line1Q_nxt[dnc_pkg::TAPS1-1-k])));
        end
        s1_nxt.i = scaleOut(acc1I, gainFirst, dnc_pkg::SHIFT1);
        s1_nxt.q = scaleOut(acc1Q, gainFirst, dnc_pkg::SHIFT1);
        s1Valid_nxt = 1'b1;

        line2I_nxt[0] = s1_r.i;
        line2Q_nxt[0] = s1_r.q;
        for (int k = 1; k < dnc_pkg::TAPS2; k++) begin
            line2I_nxt[k] = line2I_r[k-1];
        end
        for (int k = 1; k < dnc_pkg::TAPS2 + 1; k++) begin
            line2Q_nxt[k] = line2Q_r[k-1];
        end
        acc2 = '0;
        pair2 = '0;
        for (int k = 0; k < dnc_pkg::HALF2; k++) begin
            if (ph_r == dnc_pkg::PH_I) begin
                pair2 = (k == dnc_pkg::HALF2 - 1) ? 17'(line2I_r[k]) :
                        17'(line2I_r[k]) + 17'(line2I_r[dnc_pkg::TAPS2-1-k]);
            end else begin
                pair2 = (k == dnc_pkg::HALF2 - 1) ? 17'(line2Q_r[k+1]) :
                        17'(line2Q_r[k+1]) + 17'(line2Q_r[dnc_pkg::TAPS2-k]);
            end
            acc2 = acc2 + 44'(18'(dnc_pkg::COEF2[k]) * pair2);
        end
        res2 = scaleOut(acc2, gainSecond, dnc_pkg::SHIFT2);

        iHold_nxt = iHold_r;
        ph_nxt = ph_r;
        if (s1Valid_r) begin
            case (ph_r)
                dnc_pkg::PH_I: begin
                    iHold_nxt = res2;
                    ph_nxt = dnc_pkg::PH_Q;
                end
                dnc_pkg::PH_Q: begin
                    ph_nxt = dnc_pkg::PH_I;
                end
                default: begin
                    ph_nxt = dnc_pkg::PH_I;
                end
            endcase
        end

        // second stage only in low mode
        if (lowBandwidth) begin
            out_nxt = out_r;
            outValid_nxt = 1'b0;
            if (s1Valid_r && ph_r == dnc_pkg::PH_Q) begin
                out_nxt.i = iHold_r;
                out_nxt.q = res2;
                outValid_nxt = 1'b1;
            end
        end else begin
            out_nxt = s1_r;
            outValid_nxt = s1Valid_r;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // single clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= '0;
            line1I_r <= '{default: '0};
            line1Q_r <= '{default: '0};
            line2I_r <= '{default: '0};
            line2Q_r <= '{default: '0};
            s1_r <= '0;
            s1Valid_r <= 1'b0;
            out_r <= '0;
            outValid_r <= 1'b0;
            iHold_r <= '0;
            ph_r <= dnc_pkg::PH_I;
        end else begin
            phase_r <= phase_nxt;
            line1I_r <= line1I_nxt;
            line1Q_r <= line1Q_nxt;
            line2I_r <= line2I_nxt;
            line2Q_r <= line2Q_nxt;
            s1_r <= s1_nxt;
            s1Valid_r <= s1Valid_nxt;
            out_r <= out_nxt;
            outValid_r <= outValid_nxt;
            iHold_r <= iHold_nxt;
            ph_r <= ph_nxt;
        end
    end

    assign outIq = out_r;
    assign outValid = outValid_r;

endmodule

module dnc_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sample stream
    input wire logic [dnc_pkg::LANES-1:0][dnc_pkg::SMP_W-1:0] adcSamples,
    // register port
    input wire logic [dnc_pkg::ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic [dnc_pkg::REG_W-1:0] regWdata,
    output logic [dnc_pkg::REG_W-1:0] regRdata,
    // per-channel configuration
    input wire logic [dnc_pkg::CHANS-1:0] lowBandwidth,
    input wire logic [dnc_pkg::CHANS-1:0][dnc_pkg::GAIN_W-1:0] gainFirst,
    input wire logic [dnc_pkg::CHANS-1:0][dnc_pkg::GAIN_W-1:0] gainSecond,
    // per-channel results
    output dnc_pkg::dnc_iq_s [dnc_pkg::CHANS-1:0] chanIq,
    output logic [dnc_pkg::CHANS-1:0] chanValid
);

    // ----------------------------------------------------------------
    // tuning registers
    // ----------------------------------------------------------------
    logic [7:0] tuneLow_r [dnc_pkg::CHANS];
    logic [7:0] tuneLow_nxt [dnc_pkg::CHANS];
    logic [7:0] tuneHigh_r [dnc_pkg::CHANS];
    logic [7:0] tuneHigh_nxt [dnc_pkg::CHANS];
    logic [7:0] rdata_r, rdata_nxt;

    always_comb begin
        tuneLow_nxt = tuneLow_r;
        tuneHigh_nxt = tuneHigh_r;
        rdata_nxt = '0;
        if (regAddr == dnc_pkg::ADDR_C0_LOW) begin
            rdata_nxt = tuneLow_r[0];
            if (regWrite) tuneLow_nxt[0] = regWdata;
        end else if (regAddr == dnc_pkg::ADDR_C0_HIGH) begin
            rdata_nxt = tuneHigh_r[0];
            if (regWrite) tuneHigh_nxt[0] = regWdata;
        end else if (regAddr == dnc_pkg::ADDR_C1_LOW) begin
            rdata_nxt = tuneLow_r[1];
            if (regWrite) tuneLow_nxt[1] = regWdata;
        end else if (regAddr == dnc_pkg::ADDR_C1_HIGH) begin
            rdata_nxt = tuneHigh_r[1];
            if (regWrite) tuneHigh_nxt[1] = regWdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tuneLow_r <= '{default: dnc_pkg::TUNE_RESET};
            tuneHigh_r <= '{default: dnc_pkg::TUNE_RESET};
            rdata_r <= '0;
        end else begin
            tuneLow_r <= tuneLow_nxt;
            tuneHigh_r <= tuneHigh_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign regRdata = rdata_r;

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    // two independent channels
    for (genvar c = 0; c < dnc_pkg::CHANS; c++) begin : g_chan
        logic [dnc_pkg::PH_W-1:0] tuneWord;
        assign tuneWord = {tuneHigh_r[c][dnc_pkg::HIGH_BITS-1:0], tuneLow_r[c]};
        dnc_channel u_chan (
            .clk(clk),
            .rst_n(rst_n),
            .adcSamples(adcSamples),
            .tuneWord(tuneWord),
            .lowBandwidth(lowBandwidth[c]),
            .gainFirst(gainFirst[c]),
            .gainSecond(gainSecond[c]),
            .outIq(chanIq[c]),
            .outValid(chanValid[c])
        );
    end

endmodule

// file: rtl/dnc_pkg.sv
// dual downconverter package: constants, coefficient tables, carrier types
// assumes one common clock at one eighth of the converter sample rate
package dnc_pkg;

    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int LANES = 8;
    localparam int SMP_W = 12;
    localparam int MIX_W = 13;
    localparam int PH_W = 10;
    localparam int OUT_W = 16;
    localparam int ACC_W = 44;
    localparam int GAIN_W = 2;
    localparam int TAPS1 = 142;
    localparam int HALF1 = 71;
    localparam int TAPS2 = 31;
    localparam int HALF2 = 16;
    localparam int CHANS = 2;

    // ----------------------------------------------------------------
    // scaling
    // ----------------------------------------------------------------
    localparam int MIX_SHIFT = 11;
    localparam int SIN_SHIFT = 5;
    localparam int SIN_HALF = 512;
    localparam int SIN_QUART = 256;
    localparam int SIN_MAX = 2047;
    localparam int SHIFT1 = 16;
    localparam int SHIFT2 = 17;
    localparam int SAT_MAX = 32767;
    localparam int SAT_MIN = -32768;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int REG_W = 8;
    localparam logic [11:0] ADDR_C0_LOW = 12'h0131;
    localparam logic [11:0] ADDR_C0_HIGH = 12'h0132;
    localparam logic [11:0] ADDR_C1_LOW = 12'h0139;
    localparam logic [11:0] ADDR_C1_HIGH = 12'h013a;
    localparam logic [7:0] TUNE_RESET = 8'h00;
    localparam int HIGH_BITS = 2;

    // ----------------------------------------------------------------
    // filter coefficients, first half of each symmetric filter
    // ----------------------------------------------------------------
    localparam int COEF1 [HALF1] = '{
        -38, -57, -92, -132, -172, -204, -219, -207, -162, -79,
        43, 196, 369, 540, 685, 780, 800, 727, 554, 289,
        -48, -420, -778, -1069, -1238, -1242, -1055, -677, -135, 513,
        1186, 1785, 2210, 2372, 2209, 1698, 869, -200, -1382, -2516,
        -3425, -3945, -3944, -3353, -2179, -519, 1446, 3467, 5250, 6496,
        6945, 6412, 4831, 2276, -1031, -4725, -8330, -11304, -13098, -13222,
        -11306, -7160, -808, 7498, 17281, 27882, 38515, 48340, 56550, 62451,
        65536};
    localparam int COEF2 [HALF2] = '{
        126, 312, -16, -859, -628, 1217, 1428, -1944,
        -3227, 2511, 6302, -3099, -13075, 3441, 43442, 65536};

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } dnc_iq_s;

    typedef enum logic [1:0] {
        PH_I = 2'b01,
        PH_Q = 2'b10
    } dnc_phase_e;

endpackage

// file: bench/dnc_adc_model.sv
// sample source standing in for the converter core
// assumes the block takes all eight lanes on each rising edge
`timescale 1ns/1ps

module dnc_adc_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // requested level
    input wire logic signed [11:0] level,
    // sample lanes
    output logic [7:0][11:0] adcSamples
);
    initial adcSamples = '0;

    always @(posedge clk) begin
        #1;
        for (int j = 0; j < dnc_pkg::LANES; j++) begin
            adcSamples[j] = rst_n ? level : 12'h000;
        end
    end
endmodule

// file: bench/dnc_asserts.sv
// port checker for the downconverter top
// assumes binding into dnc_top
`timescale 1ns/1ps

module dnc_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [11:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    // channels
    input wire logic [1:0] lowBandwidth,
    input wire dnc_pkg::dnc_iq_s [1:0] chanIq,
    input wire logic [1:0] chanValid
);
    // ----------------------------------------
    // mode age tracking
    // ----------------------------------------
    logic [2:0] age0_r, age0_nxt, age1_r, age1_nxt;
    logic [1:0] lbPrev_r, lbPrev_nxt;
    logic mapped;
    logic st0, st1;

    assign mapped = regAddr == dnc_pkg::ADDR_C0_LOW || regAddr == dnc_pkg::ADDR_C0_HIGH
        || regAddr == dnc_pkg::ADDR_C1_LOW || regAddr == dnc_pkg::ADDR_C1_HIGH;
    assign st0 = lowBandwidth[0] == lbPrev_r[0];
    assign st1 = lowBandwidth[1] == lbPrev_r[1];

    always_comb begin
        lbPrev_nxt = lowBandwidth;
        age0_nxt = st0 ? age0_r + {2'h0, age0_r != 3'h7} : 3'h0;
        age1_nxt = st1 ? age1_r + {2'h0, age1_r != 3'h7} : 3'h0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lbPrev_r <= 2'h0;
            age0_r <= 3'h0;
            age1_r <= 3'h0;
        end else begin
            lbPrev_r <= lbPrev_nxt;
            age0_r <= age0_nxt;
            age1_r <= age1_nxt;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_rd_unmapped;
        !mapped |=> regRdata == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");
    property p_rd_write;
        regWrite && mapped ##1 (!regWrite && $stable(regAddr)) |=> regRdata == $past(regWdata, 2);
    endproperty
    a_rd_write: assert property (p_rd_write)
        else $error("tuning byte not read back");
    property p_hi0;
        !lowBandwidth[0] && st0 && age0_r >= 3'h4 |-> chanValid[0];
    endproperty
    a_hi0: assert property (p_hi0)
        else $error("channel zero missed a result");
    property p_hi1;
        !lowBandwidth[1] && st1 && age1_r >= 3'h4 |-> chanValid[1];
    endproperty
    a_hi1: assert property (p_hi1)
        else $error("channel one missed a result");
    property p_lo0;
        lowBandwidth[0] && st0 && age0_r >= 3'h6 |-> chanValid[0] != $past(chanValid[0]);
    endproperty
    a_lo0: assert property (p_lo0)
        else $error("channel zero rate not halved");
    property p_lo1;
        lowBandwidth[1] && st1 && age1_r >= 3'h6 |-> chanValid[1] != $past(chanValid[1]);
    endproperty
    a_lo1: assert property (p_lo1)
        else $error("channel one rate not halved");
    property p_hold0;
        lowBandwidth[0] && st0 && age0_r >= 3'h6 && !chanValid[0] |-> $stable(chanIq[0]);
    endproperty
    a_hold0: assert property (p_hold0)
        else $error("channel zero result moved");
    property p_hold1;
        lowBandwidth[1] && st1 && age1_r >= 3'h6 && !chanValid[1] |-> $stable(chanIq[1]);
    endproperty
    a_hold1: assert property (p_hold1)
        else $error("channel one result moved");
endmodule

bind dnc_top dnc_asserts dnc_asserts_inst (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
    .lowBandwidth(lowBandwidth), .chanIq(chanIq), .chanValid(chanValid));

// file: bench/test_dnc_top.sv
// self-checking bench for the dual downconverter
// assumes package, design, model and checker compiled first
`timescale 1ns/1ps

module test_dnc_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] regAddr = 12'h0000;
    logic regWrite = 1'b0;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic [1:0] lowBandwidth = 2'h0;
    logic [1:0][1:0] gainFirst = 4'h0;
    logic [1:0][1:0] gainSecond = 4'hf;
    dnc_pkg::dnc_iq_s [1:0] chanIq;
    logic [1:0] chanValid;
    logic [7:0][11:0] adcSamples;
    logic signed [11:0] level = 12'h3e8;
    logic [11:0] addrs [4];
    int failCount = 0;
    int checksDone = 0;
    longint sum1 = 0;
    longint sum2 = 0;

    dnc_top dnc_top_inst (.clk(clk), .rst_n(rst_n), .adcSamples(adcSamples), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
        .lowBandwidth(lowBandwidth), .gainFirst(gainFirst), .gainSecond(gainSecond),
        .chanIq(chanIq), .chanValid(chanValid));
    dnc_adc_model dnc_adc_model_inst (.clk(clk), .rst_n(rst_n), .level(level),
        .adcSamples(adcSamples));

    always #25 clk = ~clk;

    task automatic results();
        if (failCount == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failCount++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic regWr(input logic [11:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
    endtask

    task automatic regRd(input logic [11:0] a, input logic [7:0] exp);
        regWrite = 1'b0;
        regAddr = a;
        @(posedge clk);
        #1;
        check({8'h00, regRdata}, {8'h00, exp});
    endtask

    task automatic run(input int n);
        regWrite = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chkIq(input int ch, input logic [15:0] ei, input logic [15:0] eq);
        check(chanIq[ch].i, ei);
        check(chanIq[ch].q, eq);
    endtask

    task automatic near0(input int ch);
        check(16'(chanIq[ch].i > -200 && chanIq[ch].i < 200), 16'h0001);
    endtask

    task automatic rate(input int ch, input logic [15:0] exp);
        logic [15:0] n;
        n = 16'h0000;
        repeat (40) begin
            @(posedge clk);
            #1;
            n = n + 16'(chanValid[ch]);
        end
        check(n, exp);
    endtask

    function automatic logic signed [15:0] sat(input longint v);
        if (v > dnc_pkg::SAT_MAX) return 16'h7fff;
        if (v < dnc_pkg::SAT_MIN) return 16'h8000;
        return 16'(v);
    endfunction

    function automatic logic signed [15:0] exp1(input longint s, input int g);
        longint m;
        m = (s * dnc_pkg::SIN_MAX) >>> dnc_pkg::MIX_SHIFT;
        return sat(((m * sum1 <<< g) + (longint'(1) <<< (dnc_pkg::SHIFT1 - 1))) >>> dnc_pkg::SHIFT1);
    endfunction

    function automatic logic signed [15:0] exp2(input longint y, input int g);
        return sat(((y * sum2 <<< g) + (longint'(1) <<< (dnc_pkg::SHIFT2 - 1))) >>> dnc_pkg::SHIFT2);
    endfunction

    // watchdog: tests need about 1000 cycles
    initial begin
        #300000;
        failCount++;
        results();
    end

    initial begin
        addrs = '{dnc_pkg::ADDR_C0_LOW, dnc_pkg::ADDR_C0_HIGH, dnc_pkg::ADDR_C1_LOW,
            dnc_pkg::ADDR_C1_HIGH};
        for (int k = 0; k < dnc_pkg::HALF1; k++) sum1 += 2 * dnc_pkg::COEF1[k];
        for (int k = 0; k < dnc_pkg::HALF2 - 1; k++) sum2 += 2 * dnc_pkg::COEF2[k];
        sum2 += dnc_pkg::COEF2[dnc_pkg::HALF2 - 1];
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (int k = 0; k < 4; k++) regRd(addrs[k], dnc_pkg::TUNE_RESET);
        for (int k = 0; k < 4; k++) regWr(addrs[k], 8'h5a + 8'(k));
        for (int k = 0; k < 4; k++) regRd(addrs[k], 8'h5a + 8'(k));
        regWr(12'h0133, 8'hff);
        regRd(12'h0133, 8'h00);
        // restart both oscillator phases from zero
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        regWr(dnc_pkg::ADDR_C0_LOW, 8'h00);
        regWr(dnc_pkg::ADDR_C0_HIGH, 8'hfc);
        regWr(dnc_pkg::ADDR_C1_LOW, 8'h00);
        regWr(dnc_pkg::ADDR_C1_HIGH, 8'hfe);
        regRd(dnc_pkg::ADDR_C1_HIGH, 8'hfe);
        for (int g = 0; g < 4; g++) begin
            gainFirst[0] = 2'(g);
            run(60);
            chkIq(0, exp1(1000, g), 16'h0000);
            near0(1);
        end
        level = 12'h800;
        run(60);
        chkIq(0, exp1(-2048, 3), 16'h0000);
        level = 12'h3e8;
        gainFirst[0] = 2'h0;
        regWr(dnc_pkg::ADDR_C0_HIGH, 8'h02);
        regWr(dnc_pkg::ADDR_C1_HIGH, 8'h00);
        run(60);
        near0(0);
        chkIq(1, exp1(1000, 0), 16'h0000);
        rate(0, 16'h0028);
        regWr(dnc_pkg::ADDR_C0_HIGH, 8'h00);
        lowBandwidth = 2'h3;
        for (int g = 0; g < 4; g++) begin
            gainSecond[0] = 2'(g);
            run(120);
            chkIq(0, exp2(exp1(1000, 0), g), 16'h0000);
        end
        chkIq(1, exp2(exp1(1000, 0), 3), 16'h0000);
        rate(0, 16'h0014);
        rate(1, 16'h0014);
        results();
    end
endmodule
